//--- hw/ubk_pkg.sv
// Constants, types and register map of the break-capable serial port.
// Behaviour
// RL1: Break frame is a start bit, twelve zero bits, then one stop bit.
// RL2: Software sets break request and transmit enable before writing the holding register.
// RL3: A requested break begins only after a holding register write.
// RL4: The triggering byte is discarded; every break data bit is zero.
// RL5: Hardware clears the break request after the break stop bit is sent.
// RL6: The next byte is accepted during a break and sent normally afterwards.
// RL7: Shift register empty shows active or idle during a break as normally.
// RL8: A bus master header writes a dummy byte, then the sync pattern.
// RL9: Buffer empty flag sets when holding empties; software writes only then.
// RL10: A received break sets complete and framing error flags, data reads zero.
// RL11: Wake on break waits two line transitions, flags, then receives normally.
// RL12: Software should enable auto baud after a break, possibly before sleep.
// RL13: A break never aborts a character already being shifted out.
package ubk_pkg;
  localparam logic [4:0] TXCTL_OFS = 5'h00;
  localparam logic [4:0] TXDATA_OFS = 5'h04;
  localparam logic [4:0] RXCTL_OFS = 5'h08;
  localparam logic [4:0] RXDATA_OFS = 5'h0c;
  localparam logic [4:0] BAUD_OFS = 5'h10;
  localparam int TX_EN_BIT = 0;
  localparam int BRK_REQ_BIT = 1;
  localparam int SHIFT_EMPTY_BIT = 2;
  localparam int TXBE_BIT = 3;
  localparam int RXEN_BIT = 0;
  localparam int RXDONE_BIT = 1;
  localparam int FRAME_ERR_BIT = 2;
  localparam int WAKE_BIT = 16;
  localparam int ABD_BIT = 17;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0010;
  localparam logic [3:0] CHAR_LAST = 4'h7;
  localparam logic [3:0] BRK_LAST = 4'hb;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8
  } ubk_tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
  } ubk_rx_state_t;
  typedef struct packed {
    logic wake_en;
    logic abd_en;
    logic [15:0] div;
  } ubk_baud_t;
endpackage

//--- hw/ubk_uart_break.sv
// Serial port with break transmit and break receive, Avalon-MM register slave.
`timescale 1ns/100ps
module ubk_uart_break (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Serial line
  input wire logic RX_LINE,
  output logic TX_LINE
);
  import ubk_pkg::*;

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic tx_en_reg, brk_req_reg, rxen_reg;
  ubk_baud_t baud_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  ubk_tx_state_t tx_state, tx_state_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic brk_reg, brk_next;
  logic tx_line_reg;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  ubk_rx_state_t rx_state;
  logic [15:0] rx_cnt_reg;
  logic [2:0] rx_idx_reg;
  logic [7:0] rx_shift_reg, rx_data_reg;
  logic rx_done_reg, frame_err_reg, wake_edge_reg;

  // A zero divisor would stall the bit timer, so it is treated as one.
  function automatic logic [15:0] reload(input logic [15:0] div);
    reload = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
  endfunction

  // One wait state: the request is registered, then answered.
  wire req = AVS_READ | AVS_WRITE;
  wire acc_wr = ack_reg & AVS_WRITE;
  wire acc_rd = ack_reg & AVS_READ;
  wire txctl_wr = acc_wr & (AVS_ADDRESS == TXCTL_OFS) & AVS_BYTEENABLE[0];
  wire rxctl_wr = acc_wr & (AVS_ADDRESS == RXCTL_OFS) & AVS_BYTEENABLE[0];
  wire baud_lo_wr = acc_wr & (AVS_ADDRESS == BAUD_OFS) & AVS_BYTEENABLE[0];
  wire baud_mid_wr = acc_wr & (AVS_ADDRESS == BAUD_OFS) & AVS_BYTEENABLE[1];
  wire baud_hi_wr = acc_wr & (AVS_ADDRESS == BAUD_OFS) & AVS_BYTEENABLE[2];
  wire rxdata_rd = acc_rd & (AVS_ADDRESS == RXDATA_OFS);
  // Writes while the holding register is full are dropped.
  wire hold_wr = acc_wr & (AVS_ADDRESS == TXDATA_OFS) & AVS_BYTEENABLE[0] & ~hold_full_reg;
  wire tx_idle = (tx_state == TX_IDLE);
  wire tx_bit_end = (tx_cnt_reg == 16'h0000);
  wire tx_load = tx_idle & tx_en_reg & hold_full_reg;
  wire brk_stop_end = (tx_state == TX_STOP) & tx_bit_end & brk_reg;
  wire rx_bit_end = (rx_cnt_reg == 16'h0000);
  wire rx_fall = rx_s3_reg & ~rx_s2_reg;
  wire rx_edge = rx_s3_reg ^ rx_s2_reg;
  wire wake_hit = (rx_state == RX_IDLE) & baud_reg.wake_en & rx_edge & wake_edge_reg;
  wire stop_end = (rx_state == RX_STOP) & rx_bit_end;

  // RL7: idle status bit
  wire [31:0] txctl_rd = {28'h0000000, ~hold_full_reg, tx_idle, brk_req_reg, tx_en_reg};
  wire [31:0] rxctl_rd = {29'h00000000, frame_err_reg, rx_done_reg, rxen_reg};
  wire [31:0] baud_rd = {14'h0000, baud_reg.abd_en, baud_reg.wake_en, baud_reg.div};
  wire [31:0] rd_mux = (AVS_ADDRESS == TXCTL_OFS) ? txctl_rd :
                       (AVS_ADDRESS == RXCTL_OFS) ? rxctl_rd :
                       (AVS_ADDRESS == RXDATA_OFS) ? {24'h000000, rx_data_reg} :
                       (AVS_ADDRESS == BAUD_OFS) ? baud_rd : 32'h00000000;

  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign AVS_READDATA = rdata_reg;
  assign TX_LINE = tx_line_reg;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdata_reg <= (req & ~ack_reg) ? rd_mux : rdata_reg;
    end
  end

  // Software writes win over the hardware clear of the break request.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tx_en_reg <= 1'b0;
      brk_req_reg <= 1'b0;
      rxen_reg <= 1'b0;
      baud_reg <= '{wake_en: 1'b0, abd_en: 1'b0, div: BAUD_DIV_RST};
    end else begin
      if (txctl_wr) begin
        tx_en_reg <= AVS_WRITEDATA[TX_EN_BIT];
        brk_req_reg <= AVS_WRITEDATA[BRK_REQ_BIT];
      // RL5: auto clear
      end else if (brk_stop_end) begin
        brk_req_reg <= 1'b0;
      end
      if (rxctl_wr) begin
        rxen_reg <= AVS_WRITEDATA[RXEN_BIT];
      end
      if (baud_lo_wr) begin
        baud_reg.div[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (baud_mid_wr) begin
        baud_reg.div[15:8] <= AVS_WRITEDATA[15:8];
      end
      if (baud_hi_wr) begin
        baud_reg.wake_en <= AVS_WRITEDATA[WAKE_BIT];
        baud_reg.abd_en <= AVS_WRITEDATA[ABD_BIT];
      // RL11: wake ends
      end else if (wake_hit) begin
        baud_reg.wake_en <= 1'b0;
      end
    end
  end

  // RL6: buffer during break
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      hold_full_reg <= 1'b0;
      hold_reg <= 8'h00;
    end else if (hold_wr) begin
      hold_full_reg <= 1'b1;
      hold_reg <= AVS_WRITEDATA[7:0];
    // RL9: empty flag
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  always_comb begin
    tx_state_next = tx_state;
    tx_cnt_next = tx_bit_end ? reload(baud_reg.div) : tx_cnt_reg - 16'h0001;
    tx_idx_next = tx_idx_reg;
    tx_shift_next = tx_shift_reg;
    brk_next = brk_reg;
    unique case (tx_state)
      TX_IDLE: begin
        tx_cnt_next = reload(baud_reg.div);
        // RL3: start on write
        // RL13: only when idle
        if (tx_load) begin
          tx_state_next = TX_START;
          brk_next = brk_req_reg;
          // RL4: byte discarded
          tx_shift_next = brk_req_reg ? 8'h00 : hold_reg;
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          tx_state_next = TX_DATA;
          tx_idx_next = 4'h0;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_idx_next = tx_idx_reg + 4'h1;
          // RL1: twelve zeros
          if (tx_idx_reg == (brk_reg ? BRK_LAST : CHAR_LAST)) begin
            tx_state_next = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          tx_state_next = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tx_state <= TX_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_idx_reg <= 4'h0;
      tx_shift_reg <= 8'h00;
      brk_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else begin
      tx_state <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_shift_reg <= tx_shift_next;
      brk_reg <= brk_next;
      tx_line_reg <= (tx_state_next == TX_START) ? 1'b0 :
                     (tx_state_next == TX_DATA) ? tx_shift_next[0] : 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end else begin
      rx_s1_reg <= RX_LINE;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  // A break is just a character whose stop bit samples low, so it lands as zero data
  // with a framing error; the receiver then needs a fresh falling edge to restart.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rx_state <= RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_done_reg <= 1'b0;
      frame_err_reg <= 1'b0;
      wake_edge_reg <= 1'b0;
    end else begin
      rx_cnt_reg <= rx_bit_end ? reload(baud_reg.div) : rx_cnt_reg - 16'h0001;
      // A new completion wins over the clear caused by reading the data.
      if (stop_end | wake_hit) begin
        rx_done_reg <= 1'b1;
      end else if (rxdata_rd) begin
        rx_done_reg <= 1'b0;
      end
      unique case (rx_state)
        RX_IDLE: begin
          rx_cnt_reg <= {1'b0, baud_reg.div[15:1]};
          // RL11: count edges
          if (baud_reg.wake_en) begin
            wake_edge_reg <= rx_edge ? ~wake_edge_reg : wake_edge_reg;
          end else begin
            wake_edge_reg <= 1'b0;
            if (rxen_reg & rx_fall) begin
              rx_state <= RX_START;
            end
          end
        end
        RX_START: begin
          if (rx_bit_end) begin
            rx_state <= rx_s2_reg ? RX_IDLE : RX_DATA;
            rx_idx_reg <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift_reg <= {rx_s2_reg, rx_shift_reg[7:1]};
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == CHAR_LAST[2:0]) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // RL10: break reported
          if (rx_bit_end) begin
            rx_data_reg <= rx_shift_reg;
            frame_err_reg <= ~rx_s2_reg;
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_brk_stop;
    brk_stop_end ##0 !txctl_wr;
  endsequence
  property p_brk_zero;
    (tx_state == TX_DATA) && brk_reg |-> !TX_LINE;
  endproperty
  a_brk_zero: assert property (p_brk_zero) else $error("break data bit not zero"); // RL4
  property p_brk_len;
    (tx_state == TX_DATA) && brk_reg && tx_bit_end && !tx_idx_reg[3] |=> tx_state == TX_DATA;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break ended too early"); // RL1
  property p_brk_end;
    (tx_state == TX_DATA) && brk_reg && tx_bit_end && (tx_idx_reg == BRK_LAST)
      |=> (tx_state == TX_STOP) && TX_LINE;
  endproperty
  a_brk_end: assert property (p_brk_end) else $error("break stop bit missing"); // RL1
  property p_break_send_request_clr;
    s_brk_stop |=> !brk_req_reg && tx_idle;
  endproperty
  a_break_send_request_clr: assert property (p_break_send_request_clr) else $error("break request not cleared"); // RL5
  property p_start_cause;
    tx_idle ##1 !tx_idle |-> $past(hold_full_reg) && $past(tx_en_reg);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write"); // RL3
  property p_no_abort;
    !tx_idle |=> $stable(brk_reg);
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("frame kind changed mid frame"); // RL13
  property p_buf_accept;
    hold_wr && !tx_idle |=> hold_full_reg && (hold_reg == $past(AVS_WRITEDATA[7:0]));
  endproperty
  a_buf_accept: assert property (p_buf_accept) else $error("byte lost during frame"); // RL6
  property p_shift_register_empty_read;
    AVS_READ && !ack_reg && (AVS_ADDRESS == TXCTL_OFS)
      |=> AVS_READDATA[SHIFT_EMPTY_BIT] == $past(tx_idle);
  endproperty
  a_shift_register_empty_read: assert property (p_shift_register_empty_read) else $error("shift empty bit wrong"); // RL7
  property p_buf_empty;
    tx_load |=> !hold_full_reg && txctl_rd[TXBE_BIT];
  endproperty
  a_buf_empty: assert property (p_buf_empty) else $error("buffer empty not set"); // RL9
  property p_rx_break;
    stop_end && !rx_s2_reg && (rx_shift_reg == 8'h00)
      |=> rx_done_reg && frame_err_reg && (rx_data_reg == 8'h00);
  endproperty
  a_rx_break: assert property (p_rx_break) else $error("break not reported"); // RL10
  property p_wake;
    wake_hit && !baud_hi_wr |=> rx_done_reg && !baud_reg.wake_en;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not flagged"); // RL11
endmodule

//--- testbench/ubk_node.sv
// Remote serial node model: sends frames to the port and decodes its transmit line.
`timescale 1ns/100ps
module ubk_node #(
  parameter int DIV = 8
) (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_line
);
  logic [7:0] fdata[$];
  int flen[$];
  logic [7:0] sh;
  int n;

  initial rx_line = 1'b1;

  // frame and break drive
  // The line returns high after the last bit, because an idle line is held high.
  task automatic send(input logic [15:0] bits, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      rx_line <= bits[i];
      repeat (DIV) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  // frame decode
  // Sampling mid bit keeps the decoder clear of the edge on which the line changes.
  initial begin
    forever begin
      @(negedge tx_line);
      repeat (DIV / 2) @(posedge clk);
      sh = 8'h00;
      n = 0;
      do begin
        repeat (DIV) @(posedge clk);
        if (n < 8) begin
          sh[n] = tx_line;
        end
        n++;
      end while (!(n >= 9 && tx_line === 1'b1) && n < 20);
      fdata.push_back(sh);
      flen.push_back(n);
    end
  end
endmodule

//--- testbench/ubk_uart_break_bench.sv
// Self-checking bench of the break-capable serial port.
`timescale 1ns/100ps
module ubk_uart_break_bench;
  import ubk_pkg::*;
  localparam int DIV = 8;
  logic clk, rst_b, rd_req, wr_req, tx_line, rx_line, waitreq;
  logic [4:0] adr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, v;
  int error_cnt = 0;
  int checks_done = 0;
  int lens[3] = '{9, 13, 9};
  logic [7:0] dats[3] = '{8'ha5, 8'h00, 8'h55};

  ubk_uart_break DUT (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd_req),
    .AVS_WRITE(wr_req), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .RX_LINE(rx_line), .TX_LINE(tx_line));
  ubk_node #(.DIV(DIV)) node (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdata <= d;
    be <= 4'hf;
    wr_req <= wr;
    rd_req <= ~wr;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("BAD %0t bus cycle never answered", $time);
    end
    v = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(v, exp);
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    rst_b = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    adr = 5'h00;
    be = 4'h0;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(TXCTL_OFS, 32'h0000000c);
    rdc(BAUD_OFS, 32'h00000010);
    rdc(5'h14, 32'h0);
    acc(1'b1, BAUD_OFS, 32'h00020008);
    rdc(BAUD_OFS, 32'h00020008);
    // A character is in flight when the break is requested, so the break must queue.
    acc(1'b1, TXCTL_OFS, 32'h1);
    acc(1'b1, TXDATA_OFS, 32'ha5);
    acc(1'b1, TXCTL_OFS, 32'h3);
    acc(1'b1, TXDATA_OFS, 32'hff);
    rdc(TXCTL_OFS, 32'h3);
    for (int i = 0; i < 100 && v[TXBE_BIT] !== 1'b1; i++) begin
      acc(1'b0, TXCTL_OFS, 32'h0);
    end
    rdc(TXCTL_OFS, 32'hb);
    acc(1'b1, TXDATA_OFS, 32'h55);
    for (int i = 0; i < 3000 && node.flen.size() < 3; i++) begin
      @(posedge clk);
    end
    repeat (2 * DIV) @(posedge clk);
    rdc(TXCTL_OFS, 32'hd);
    chk(32'(node.flen.size()), 32'd3);
    for (int i = 0; i < 3 && i < node.flen.size(); i++) begin
      chk(32'(node.flen[i]), 32'(lens[i]));
      chk({24'h0, node.fdata[i]}, {24'h0, dats[i]});
    end
    acc(1'b1, RXCTL_OFS, 32'h1);
    node.send({6'h00, 1'b1, 8'h3c, 1'b0}, 10);
    settle();
    rdc(RXCTL_OFS, 32'h3);
    rdc(RXDATA_OFS, 32'h3c);
    rdc(RXCTL_OFS, 32'h1);
    node.send(16'h2000, 14);
    settle();
    rdc(RXCTL_OFS, 32'h7);
    rdc(RXDATA_OFS, 32'h0);
    acc(1'b1, BAUD_OFS, 32'h00030008);
    node.send(16'h2000, 14);
    settle();
    acc(1'b0, RXCTL_OFS, 32'h0);
    chk(32'(v[RXDONE_BIT]), 32'h1);
    rdc(BAUD_OFS, 32'h00020008);
    rdc(RXDATA_OFS, 32'h0);
    node.send({6'h00, 1'b1, 8'h81, 1'b0}, 10);
    settle();
    acc(1'b0, RXCTL_OFS, 32'h0);
    chk(32'(v[RXDONE_BIT]), 32'h1);
    rdc(RXDATA_OFS, 32'h81);
    end_sim();
  end

  // The run needs about eight hundred cycles; this limit leaves a wide margin.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end
endmodule
